// file: rtl/wdt_count_if.sv
`timescale 1ns/1ns
interface wdt_count_if #(parameter int W = 23);
  logic tick;
  logic run;
  logic clear;
  logic [4:0] ratio_sel;
  logic [W-1:0] count;
  logic timeout;
  modport ctl (output tick, output run, output clear, output ratio_sel,
               input count, input timeout);
  modport cnt (input tick, input run, input clear, input ratio_sel,
               output count, output timeout);
endinterface : wdt_count_if

// file: rtl/wdt_counter.sv
`timescale 1ns/1ns
module wdt_counter #(
  parameter int W = 23
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // counter port
  wdt_count_if.cnt cif
);
  import wdt_pkg::*;

  // refused at elaboration: the longest ratio would never be reached
  if (W < int'(PS_MAX_CODE) + PS_BASE_SHIFT) begin : g_too_narrow
    $error("counter too narrow for largest ratio");
  end

  logic [W-1:0] terminal;
  logic [4:0] code;

  // reserved codes fall back to the shortest ratio
  always_comb begin
    code = (cif.ratio_sel > PS_MAX_CODE) ? 5'h00 : cif.ratio_sel;
    terminal = W'((64'h1 << (code + PS_BASE_SHIFT)) - 64'h1);
  end

  // ----------------------------------------------------------------
  // count selected clock edges up to the ratio
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cif.count <= '0;
    end else if (cif.clear || !cif.run) begin
      cif.count <= '0;
    end else if (cif.tick) begin
      cif.count <= (cif.count >= terminal) ? '0 : cif.count + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cif.timeout <= 1'b0;
    end else begin
      cif.timeout <= cif.run && !cif.clear && cif.tick && (cif.count >= terminal);
    end
  end

  chk_timeout_at_ratio: assert property (@(posedge pclk) disable iff (!presetn)
    cif.timeout |-> $past(cif.count) == $past(terminal))
    else $error("time-out away from selected ratio");
endmodule : wdt_counter

// file: rtl/wdt_pkg.sv
package wdt_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_OFFSET = 12'h18c;
  localparam logic [11:0] STATUS_OFFSET = 12'h190;
  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  localparam int CS_BIT = 7;
  localparam int UNUSED_BIT = 6;
  localparam int PS_LSB = 1;
  localparam int PS_MSB = 5;
  localparam int SEN_BIT = 0;
  localparam logic [4:0] PS_RESET = 5'h0b;
  localparam logic [4:0] PS_MAX_CODE = 5'h12;
  localparam int PS_BASE_SHIFT = 5;
  localparam logic [7:0] CTRL_RESET = 8'h16;
  // ----------------------------------------------------------------
  // status fields (active-low flags, 1 after reset)
  // ----------------------------------------------------------------
  localparam int TO_BIT = 0;
  localparam int PD_BIT = 1;
  localparam int WATCHDOG_RESET_FLAG_N_BIT = 2;
  localparam logic [2:0] STATUS_RESET = 3'h7;
  // ----------------------------------------------------------------
  // mode field
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_SOFT = 2'h1;
  localparam logic [1:0] MODE_AWAKE = 2'h2;
  localparam logic [1:0] MODE_ALWAYS = 2'h3;
  localparam int COUNT_W = 23;
endpackage : wdt_pkg

// file: rtl/wdt_top.sv
// How it works
// - clear count on sleep entry, keep counting
// - clear count again when leaving sleep
// - time-out asleep wakes, never resets
// - sleep time-out drops time-out and power-down flags
// - sleep time-out drops watchdog reset flag
// - bit 7 picks crystal or internal oscillator
// - prescale code n gives ratio 2^(n+5)
// - reserved prescale codes act as 1:32
// - prescale resets to code 01011
// - software enable matters only in mode 01
// - control register at 0x18c, bit 6 empty
// - mode 11 always, 10 awake, 00 off
// - any reset, clear instruction, control register write clears count
// - awake time-out requests system reset
//
// The APB register port was decided locally.
`timescale 1ns/1ns
module wdt_top (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // device state and configuration
  input wire logic [1:0] watchdog_mode_config,
  input wire logic sleep_state,
  input wire logic clear_watchdog_instruction,
  // count clock sources, sampled as levels
  input wire logic secondary_crystal_osc,
  input wire logic low_freq_internal_osc,
  // results
  output logic system_reset_req,
  output logic wake_req,
  output logic timeout_flag_n,
  output logic powerdown_flag_n,
  output logic watchdog_reset_flag_n
);
  import wdt_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] watchdog_control_reg;
  logic [2:0] status_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic pready_reg;
  logic sleep_reg;
  logic secondary_crystal_osc_reg;
  logic lfosc_reg;
  logic reset_req_reg;
  logic wake_reg;

  wdt_count_if #(.W(COUNT_W)) cif ();

  wdt_counter #(.W(COUNT_W)) u_counter (
    .pclk(pclk),
    .presetn(presetn),
    .cif(cif)
  );

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic setup_phase;
  logic apb_write;
  logic ctrl_write;
  logic status_write;
  logic mapped;
  assign setup_phase = psel && !penable;
  assign apb_write = psel && penable && pready_reg && pwrite;
  assign ctrl_write = apb_write && (paddr == CTRL_OFFSET);
  assign status_write = apb_write && (paddr == STATUS_OFFSET);
  assign mapped = (paddr == CTRL_OFFSET) || (paddr == STATUS_OFFSET);

  // zero wait states: data prepared in setup, held through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0;
      pslverr_reg <= 1'b0;
    end else if (setup_phase) begin
      pslverr_reg <= !mapped;
      if (!pwrite && paddr == CTRL_OFFSET) begin
        prdata_reg <= {24'h0, watchdog_control_reg};
      end else if (!pwrite && paddr == STATUS_OFFSET) begin
        prdata_reg <= {29'h0, status_reg};
      end else begin
        prdata_reg <= 32'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_control_reg <= CTRL_RESET;
    end else if (ctrl_write) begin
      watchdog_control_reg <= pwdata[7:0] & ~(8'h01 << UNUSED_BIT);
    end
  end

  // ----------------------------------------------------------------
  // clock source select and edge detect
  // ----------------------------------------------------------------
  logic tick;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      secondary_crystal_osc_reg <= 1'b0;
      lfosc_reg <= 1'b0;
    end else begin
      secondary_crystal_osc_reg <= secondary_crystal_osc;
      lfosc_reg <= low_freq_internal_osc;
    end
  end
  always_comb begin
    if (watchdog_control_reg[CS_BIT]) begin
      tick = secondary_crystal_osc && !secondary_crystal_osc_reg;
    end else begin
      tick = low_freq_internal_osc && !lfosc_reg;
    end
  end

  // ----------------------------------------------------------------
  // operating mode
  // ----------------------------------------------------------------
  logic active;
  always_comb begin
    unique case (watchdog_mode_config)
      MODE_ALWAYS: active = 1'b1;
      MODE_AWAKE: active = !sleep_state;
      MODE_SOFT: active = watchdog_control_reg[SEN_BIT];
      MODE_OFF: active = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_reg <= 1'b0;
    end else begin
      sleep_reg <= sleep_state;
    end
  end

  logic sleep_enter;
  logic sleep_exit;
  assign sleep_enter = sleep_state && !sleep_reg;
  assign sleep_exit = !sleep_state && sleep_reg;

  assign cif.tick = tick;
  assign cif.run = active;
  assign cif.ratio_sel = watchdog_control_reg[PS_MSB:PS_LSB];
  // both sleep edges restart the count from zero
  assign cif.clear = sleep_enter || sleep_exit
                   || clear_watchdog_instruction || ctrl_write;

  // ----------------------------------------------------------------
  // time-out handling
  // ----------------------------------------------------------------
  // sleep state is sampled with the time-out, one cycle after the tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_req_reg <= 1'b0;
      wake_reg <= 1'b0;
    end else begin
      reset_req_reg <= cif.timeout && !sleep_state;
      wake_reg <= cif.timeout && sleep_state;
    end
  end

  // hardware clearing of a flag wins over a software write of one
  logic [2:0] status_next;
  always_comb begin
    status_next = status_reg;
    if (status_write) begin
      status_next = status_reg | pwdata[2:0];
    end
    if (sleep_enter) begin
      status_next[PD_BIT] = 1'b0;
      status_next[TO_BIT] = 1'b1;
    end
    if (cif.timeout) begin
      status_next[WATCHDOG_RESET_FLAG_N_BIT] = 1'b0;
      if (sleep_state) begin
        status_next[TO_BIT] = 1'b0;
        status_next[PD_BIT] = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= STATUS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign system_reset_req = reset_req_reg;
  assign wake_req = wake_reg;
  assign timeout_flag_n = status_reg[TO_BIT];
  assign powerdown_flag_n = status_reg[PD_BIT];
  assign watchdog_reset_flag_n = status_reg[WATCHDOG_RESET_FLAG_N_BIT];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_ctrl_write;
    psel && penable && pwrite && paddr == CTRL_OFFSET;
  endsequence
  sequence s_sleep_timeout;
    cif.timeout && sleep_state;
  endsequence
  sequence s_awake_timeout;
    cif.timeout && !sleep_state;
  endsequence

  chk_sleep_entry_clear: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(sleep_state) |=> cif.count == '0)
    else $error("count not cleared on sleep entry");
  chk_sleep_exit_clear: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(sleep_state) |=> cif.count == '0)
    else $error("count not cleared on sleep exit");
  chk_no_sleep_reset: assert property (@(posedge pclk) disable iff (!presetn)
    s_sleep_timeout |=> wake_req && !system_reset_req)
    else $error("sleep time-out did not wake");
  chk_sleep_flags: assert property (@(posedge pclk) disable iff (!presetn)
    s_sleep_timeout |=> !timeout_flag_n && !powerdown_flag_n)
    else $error("flags not cleared on sleep time-out");
  chk_watchdog_reset_flag_n_flag: assert property (@(posedge pclk) disable iff (!presetn)
    cif.timeout |=> !watchdog_reset_flag_n)
    else $error("watchdog reset flag not cleared");
  chk_source_select: assert property (@(posedge pclk) disable iff (!presetn)
    watchdog_control_reg[CS_BIT] && $rose(low_freq_internal_osc)
      && !$rose(secondary_crystal_osc) |-> !tick)
    else $error("wrong count clock used");
  chk_reset_prescale: assert property (@(posedge pclk)
    $rose(presetn) |-> watchdog_control_reg[PS_MSB:PS_LSB] == PS_RESET)
    else $error("prescale reset value wrong");
  chk_soft_enable: assert property (@(posedge pclk) disable iff (!presetn)
    watchdog_mode_config == MODE_SOFT && !watchdog_control_reg[SEN_BIT]
      |=> cif.count == '0 && !cif.timeout)
    else $error("counting while software disabled");
  chk_bit6_zero: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && paddr == CTRL_OFFSET |=> prdata[UNUSED_BIT] == 1'b0)
    else $error("unimplemented bit reads one");
  chk_mode_off: assert property (@(posedge pclk) disable iff (!presetn)
    watchdog_mode_config == MODE_OFF [*2] |-> cif.count == '0 && !cif.timeout)
    else $error("counting in off mode");
  chk_write_clears: assert property (@(posedge pclk) disable iff (!presetn)
    s_ctrl_write or clear_watchdog_instruction |=> cif.count == '0)
    else $error("count not cleared");
  chk_awake_reset: assert property (@(posedge pclk) disable iff (!presetn)
    s_awake_timeout |=> system_reset_req ##1 !system_reset_req)
    else $error("awake time-out gave no reset");

  // ----------------------------------------------------------------
  // checks of gating and counting
  // ----------------------------------------------------------------
  // requests may only follow a time-out, never a clear or a write
  chk_req_on_timeout: assert property (@(posedge pclk) disable iff (!presetn)
    !cif.timeout |=> !wake_req && !system_reset_req)
    else $error("request without time-out");
  chk_awake_no_wake: assert property (@(posedge pclk) disable iff (!presetn)
    s_awake_timeout |=> !wake_req)
    else $error("awake time-out woke the device");
  chk_wake_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    s_sleep_timeout |=> wake_req ##1 !wake_req)
    else $error("wake request not a single pulse");
  chk_sleep_disable: assert property (@(posedge pclk) disable iff (!presetn)
    watchdog_mode_config != MODE_SOFT && watchdog_mode_config != MODE_ALWAYS
      && sleep_state |-> ##1 cif.count == '0)
    else $error("counting asleep while disabled");
  // asleep in always-on mode, every tick must move the count
  chk_sleep_count: assert property (@(posedge pclk) disable iff (!presetn)
    watchdog_mode_config == MODE_ALWAYS && sleep_state && tick && !cif.clear
      |=> cif.count != $past(cif.count))
    else $error("count stalled while asleep");
  chk_count_holds: assert property (@(posedge pclk) disable iff (!presetn)
    active && !tick && !cif.clear |=> $stable(cif.count))
    else $error("count moved without a tick");
  chk_reserved_code: assert property (@(posedge pclk) disable iff (!presetn)
    cif.timeout && watchdog_control_reg[PS_MSB:PS_LSB] > PS_MAX_CODE
      |-> $past(cif.count) == COUNT_W'(32'h1f))
    else $error("reserved code not at shortest ratio");
  chk_ctrl_bit6: assert property (@(posedge pclk) disable iff (!presetn)
    !watchdog_control_reg[UNUSED_BIT])
    else $error("unimplemented control bit set");
endmodule : wdt_top

// file: sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import wdt_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr, ua;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] watchdog_mode_config;
  logic sleep_state, clear_watchdog_instruction, secondary_crystal_osc, low_freq_internal_osc;
  logic system_reset_req, wake_req, timeout_flag_n, powerdown_flag_n, watchdog_reset_flag_n;
  logic [4:0] code;
  logic [5:0] mt [7];
  int n_fail, n_checks, n_rst, n_wake, k;

  wdt_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .watchdog_mode_config(watchdog_mode_config),
    .sleep_state(sleep_state), .clear_watchdog_instruction(clear_watchdog_instruction),
    .secondary_crystal_osc(secondary_crystal_osc),
    .low_freq_internal_osc(low_freq_internal_osc), .system_reset_req(system_reset_req),
    .wake_req(wake_req), .timeout_flag_n(timeout_flag_n),
    .powerdown_flag_n(powerdown_flag_n), .watchdog_reset_flag_n(watchdog_reset_flag_n));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // request pulses are one cycle wide, so count them as they pass
  always @(posedge pclk) begin
    if (system_reset_req === 1'b1) n_rst++;
    if (wake_req === 1'b1) n_wake++;
  end

  // ----------------------------------------------------------------
  // reporting and comparison
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic fail_msg(string m);
    $display("unexpected at %0t: %s", $time, m);
    n_fail++;
  endtask : fail_msg

  task automatic check_val(logic [31:0] got, logic [31:0] exp, string what);
    n_checks++;
    if (got !== exp) fail_msg($sformatf("%s got %h want %h", what, got, exp));
  endtask : check_val

  task automatic check_events(int er, int ew);
    n_checks++;
    if (n_rst != er || n_wake != ew) fail_msg($sformatf("events %0d/%0d", n_rst, n_wake));
    n_rst = 0;
    n_wake = 0;
  endtask : check_events

  task automatic check_flags(logic [2:0] exp);
    check_val({29'h0, watchdog_reset_flag_n, powerdown_flag_n, timeout_flag_n}, {29'h0, exp},
      "flags");
  endtask : check_flags

  // ----------------------------------------------------------------
  // apb master and stimulus helpers
  // ----------------------------------------------------------------
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    int guard;
    guard = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      guard++;
    end while (pready !== 1'b1 && guard < 50);
    if (guard >= 50) fail_msg("no ready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rd_chk(logic [11:0] a, logic [31:0] exp, logic exp_err);
    apb(1'b0, a, 32'h0);
    check_val(rd, exp, "read data");
    check_val({31'h0, err}, {31'h0, exp_err}, "slverr");
  endtask : rd_chk

  task automatic ticks(int n, logic xtal);
    repeat (n) begin
      if (xtal) secondary_crystal_osc <= 1'b1;
      else low_freq_internal_osc <= 1'b1;
      @(posedge pclk);
      secondary_crystal_osc <= 1'b0;
      low_freq_internal_osc <= 1'b0;
      @(posedge pclk);
    end
    repeat (4) @(posedge pclk);
  endtask : ticks

  // one tick short of the ratio must stay quiet, the last one must give the expected events
  task automatic expect_out(int n, logic xtal, int er, int ew);
    ticks(n - 1, xtal);
    check_events(0, 0);
    ticks(1, xtal);
    check_events(er, ew);
  endtask : expect_out

  function automatic int ratio(logic [4:0] c);
    if (c > PS_MAX_CODE) return 32;
    return 1 << (int'(c) + PS_BASE_SHIFT);
  endfunction : ratio

  initial begin
    #3000000;
    fail_msg("watchdog expired");
    tally_and_finish;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, sleep_state} = '0;
    {clear_watchdog_instruction, secondary_crystal_osc, low_freq_internal_osc} = '0;
    watchdog_mode_config = MODE_ALWAYS;
    presetn = 1'b0;
    void'($urandom(32'h8ed6));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check_flags(STATUS_RESET);
    rd_chk(CTRL_OFFSET, {24'h0, CTRL_RESET}, 1'b0);
    rd_chk(STATUS_OFFSET, {29'h0, STATUS_RESET}, 1'b0);
    ua = 12'h194 + 12'(4 * $urandom_range(0, 10));
    apb(1'b1, ua, $urandom);
    check_val({31'h0, err}, 32'h1, "unmapped write");
    rd_chk(ua, 32'h0, 1'b1);
    apb(1'b1, CTRL_OFFSET, 32'hff);
    rd_chk(CTRL_OFFSET, 32'hbf, 1'b0);
    $display("test registers done");
    for (int i = 0; i < 5; i++) begin
      code = (i < 3) ? 5'(i) : (i == 3) ? 5'($urandom_range(19, 30)) : 5'h1f;
      apb(1'b1, CTRL_OFFSET, {26'h0, code, 1'b0});
      expect_out(ratio(code), 1'b0, 1, 0);
    end
    check_flags(3'b011);
    apb(1'b1, STATUS_OFFSET, 32'h7);
    check_flags(3'b111);
    $display("test ratios done");
    apb(1'b1, CTRL_OFFSET, 32'h80);
    ticks(40, 1'b0);
    check_events(0, 0);
    expect_out(32, 1'b1, 1, 0);
    $display("test clock select done");
    apb(1'b1, CTRL_OFFSET, 32'h0);
    k = $urandom_range(1, 31);
    ticks(k, 1'b0);
    clear_watchdog_instruction <= 1'b1;
    @(posedge pclk);
    clear_watchdog_instruction <= 1'b0;
    expect_out(32, 1'b0, 1, 0);
    ticks(k, 1'b0);
    apb(1'b1, CTRL_OFFSET, 32'h0);
    expect_out(32, 1'b0, 1, 0);
    $display("test clears done");
    apb(1'b1, STATUS_OFFSET, 32'h7);
    ticks(k, 1'b0);
    sleep_state <= 1'b1;
    repeat (2) @(posedge pclk);
    check_flags(3'b101);
    expect_out(32, 1'b0, 0, 1);
    check_flags(3'b000);
    rd_chk(STATUS_OFFSET, 32'h0, 1'b0);
    apb(1'b1, CTRL_OFFSET, 32'h0);
    ticks(k, 1'b0);
    sleep_state <= 1'b0;
    @(posedge pclk);
    expect_out(32, 1'b0, 1, 0);
    $display("test sleep done");
    // mode, enable, asleep, reset expected, wake expected
    mt = '{6'b00_1_0_0_0, 6'b01_0_0_0_0, 6'b01_1_0_1_0, 6'b01_1_1_0_1,
           6'b10_0_0_1_0, 6'b10_0_1_0_0, 6'b11_0_1_0_1};
    for (int i = 0; i < 7; i++) begin
      watchdog_mode_config <= mt[i][5:4];
      sleep_state <= mt[i][2];
      @(posedge pclk);
      apb(1'b1, CTRL_OFFSET, {31'h0, mt[i][3]});
      expect_out(32, 1'b0, int'(mt[i][1]), int'(mt[i][0]));
    end
    $display("test modes done");
    tally_and_finish;
  end
endmodule : tb_top
